// *** adc_power_mode_sequencer.sv ***
// host-side power-mode sequencer driving a multichannel audio adc
// How it works
// - shutdown pin held low until supplies settle
// - release pin only once supplies are stable
// - after release, wait 1 ms before access
// - clear sleep, then wait 1 ms
// - optional defaults rewrite; skipped here
// - write channels, then slots, then power
// - serial clocks start after sleep clear
// - set sleep, then wait 6 ms
// - stop clocks only when status bit reads one, or on shutdown
// - resume: clear sleep, wait, restart clocks
// - shutdown pin low forces full restart
`timescale 1ns/100ps
`include "adc_pwr_seq_defines.svh"

module adc_power_mode_sequencer #(
	parameter int INIT_CYC   = `INIT_WAIT_CYC,
	parameter int WAKE_CYC   = `WAKE_WAIT_CYC,
	parameter int SLEEP_CYC  = `SLEEP_WAIT_CYC,
	parameter int BCLK_HALF  = `BCLK_HALF_DEF,
	parameter int FRAME_BITS = `FRAME_BITS_DEF
) (
	input  wire logic       REF_CLK,
	input  wire logic       RSTN,
	input  wire logic       SUPPLY_OK,
	input  wire logic       CMD_WAKE,
	input  wire logic       CMD_SLEEP,
	input  wire logic       CMD_SHUTDOWN,
	input  wire logic [7:0] CH_EN,
	input  wire logic [7:0] SLOT_EN,
	input  wire logic [7:0] PWR_EN,
	output logic            REG_REQ,
	output logic            REG_WRITE,
	output logic      [7:0] REG_ADDR,
	output logic      [7:0] REG_WDATA,
	input  wire logic       REG_ACK,
	input  wire logic [7:0] REG_RDATA,
	output logic            SHUTDOWN_N_PIN,
	output logic            BIT_CLK,
	output logic            FRAME_SYNC,
	output logic            SLEEP_DONE,
	output logic            RECORDING,
	output logic      [3:0] STATE_CODE
);

	// ==========================================================
	// reset release
	logic                      rst_s1_reg;
	logic                      rst_n;
	adc_pwr_seq_pkg::seq_state_t state_reg;
	adc_pwr_seq_pkg::seq_state_t state_next;
	logic                      sup_s1_reg;
	logic                      sup_s2_reg;
	logic                      sup_s3_reg;
	logic                      supply_ok_reg;
	logic [31:0]               wait_reg;
	logic                      wait_zero;
	logic                      acc_done;
	logic                      force_shdn;
	logic                      cfg_done_reg;
	logic                      sleep_done_reg;
	logic                      clk_run_reg;
	logic                      req_reg;
	logic                      write_reg;
	logic [7:0]                addr_reg;
	logic [7:0]                wdata_reg;
	logic                      pin_reg;
	logic [15:0]               div_reg;
	logic [15:0]               bit_reg;
	logic                      bclk_reg;
	logic                      frame_sync_reg;

	// assert asynchronously, release through two flops
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_s1_reg <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n      <= rst_s1_reg;
		end
	end

	// ==========================================================
	// supply-good pin synchroniser
	// the level only changes once the second and third flops agree,
	// so a single metastable sample cannot release the shutdown pin
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			sup_s1_reg    <= 1'b0;
			sup_s2_reg    <= 1'b0;
			sup_s3_reg    <= 1'b0;
			supply_ok_reg <= 1'b0;
		end else begin
			sup_s1_reg <= SUPPLY_OK;
			sup_s2_reg <= sup_s1_reg;
			sup_s3_reg <= sup_s2_reg;
			if (sup_s2_reg == sup_s3_reg) begin
				supply_ok_reg <= sup_s3_reg;
			end
		end
	end

	// ==========================================================
	// sequencer
	assign wait_zero  = (wait_reg == 32'h0000_0000);
	assign acc_done   = req_reg & REG_ACK;
	assign force_shdn = CMD_SHUTDOWN | ~supply_ok_reg;

	// next-state choice; shutdown overrides everything
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			adc_pwr_seq_pkg::ST_HWSHDN: begin
				if (supply_ok_reg && !CMD_SHUTDOWN) begin
					state_next = adc_pwr_seq_pkg::ST_INIT_WAIT;
				end
			end
			adc_pwr_seq_pkg::ST_INIT_WAIT: begin
				if (wait_zero) begin
					state_next = adc_pwr_seq_pkg::ST_SLEEP;
				end
			end
			adc_pwr_seq_pkg::ST_SLEEP: begin
				if (CMD_WAKE) begin
					state_next = adc_pwr_seq_pkg::ST_WAKE_WR;
				end
			end
			adc_pwr_seq_pkg::ST_WAKE_WR: begin
				if (acc_done) begin
					state_next = adc_pwr_seq_pkg::ST_WAKE_WAIT;
				end
			end
			adc_pwr_seq_pkg::ST_WAKE_WAIT: begin
				if (wait_zero && cfg_done_reg) begin
					state_next = adc_pwr_seq_pkg::ST_ACTIVE;
				end else if (wait_zero) begin
					state_next = adc_pwr_seq_pkg::ST_CFG_CH;
				end
			end
			adc_pwr_seq_pkg::ST_CFG_CH: begin
				if (acc_done) begin
					state_next = adc_pwr_seq_pkg::ST_CFG_SLOT;
				end
			end
			adc_pwr_seq_pkg::ST_CFG_SLOT: begin
				if (acc_done) begin
					state_next = adc_pwr_seq_pkg::ST_CFG_PWR;
				end
			end
			adc_pwr_seq_pkg::ST_CFG_PWR: begin
				if (acc_done) begin
					state_next = adc_pwr_seq_pkg::ST_ACTIVE;
				end
			end
			adc_pwr_seq_pkg::ST_ACTIVE: begin
				if (CMD_SLEEP) begin
					state_next = adc_pwr_seq_pkg::ST_SLEEP_WR;
				end
			end
			adc_pwr_seq_pkg::ST_SLEEP_WR: begin
				if (acc_done) begin
					state_next = adc_pwr_seq_pkg::ST_SLEEP_WAIT;
				end
			end
			adc_pwr_seq_pkg::ST_SLEEP_WAIT: begin
				if (wait_zero) begin
					state_next = adc_pwr_seq_pkg::ST_STAT_RD;
				end
			end
			adc_pwr_seq_pkg::ST_STAT_RD: begin
				// poll again until the device reports power-down done
				if (acc_done && REG_RDATA[`SLEEP_DONE_BIT]) begin
					state_next = adc_pwr_seq_pkg::ST_SLEEP;
				end
			end
			default: begin
				state_next = adc_pwr_seq_pkg::ST_HWSHDN;
			end
		endcase
		if (force_shdn) begin
			state_next = adc_pwr_seq_pkg::ST_HWSHDN;
		end
	end

	// state register
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= adc_pwr_seq_pkg::ST_HWSHDN;
		end else begin
			state_reg <= state_next;
		end
	end

	// wait timer, loaded on entry to each waiting state
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			wait_reg <= 32'h0000_0000;
		end else if (state_next != state_reg) begin
			unique case (state_next)
				adc_pwr_seq_pkg::ST_INIT_WAIT:  wait_reg <= 32'(INIT_CYC);
				adc_pwr_seq_pkg::ST_WAKE_WAIT:  wait_reg <= 32'(WAKE_CYC);
				adc_pwr_seq_pkg::ST_SLEEP_WAIT: wait_reg <= 32'(SLEEP_CYC);
				default:                        wait_reg <= 32'h0000_0000;
			endcase
		end else if (!wait_zero) begin
			wait_reg <= wait_reg - 32'h0000_0001;
		end
	end

	// configuration is kept by the device across sleep; a hard
	// shutdown loses it, so the next wake writes it again
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			cfg_done_reg <= 1'b0;
		end else if (state_reg == adc_pwr_seq_pkg::ST_HWSHDN) begin
			cfg_done_reg <= 1'b0;
		end else if (state_reg == adc_pwr_seq_pkg::ST_CFG_PWR && acc_done) begin
			cfg_done_reg <= 1'b1;
		end
	end

	// sleep-done flag holds the last status bit seen, cleared on wake or shutdown
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			sleep_done_reg <= 1'b0;
		end else if (state_next == adc_pwr_seq_pkg::ST_WAKE_WR ||
			     state_next == adc_pwr_seq_pkg::ST_HWSHDN) begin
			sleep_done_reg <= 1'b0;
		end else if (state_reg == adc_pwr_seq_pkg::ST_STAT_RD && acc_done) begin
			sleep_done_reg <= REG_RDATA[`SLEEP_DONE_BIT];
		end
	end

	// ==========================================================
	// register access requests
	// request held until acknowledged, dropped for one cycle between
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			req_reg   <= 1'b0;
			write_reg <= 1'b0;
			addr_reg  <= 8'h00;
			wdata_reg <= 8'h00;
		end else if (acc_done || force_shdn) begin
			req_reg <= 1'b0;
		end else if (!req_reg) begin
			unique case (state_reg)
				adc_pwr_seq_pkg::ST_WAKE_WR: begin
					req_reg   <= 1'b1;
					write_reg <= 1'b1;
					addr_reg  <= `SLEEP_CTRL_ADDR;
					wdata_reg <= `SLEEP_CLEAR_VAL;
				end
				adc_pwr_seq_pkg::ST_CFG_CH: begin
					req_reg   <= 1'b1;
					write_reg <= 1'b1;
					addr_reg  <= `IN_CH_EN_ADDR;
					wdata_reg <= CH_EN;
				end
				adc_pwr_seq_pkg::ST_CFG_SLOT: begin
					req_reg   <= 1'b1;
					write_reg <= 1'b1;
					addr_reg  <= `OUT_SLOT_EN_ADDR;
					wdata_reg <= SLOT_EN;
				end
				adc_pwr_seq_pkg::ST_CFG_PWR: begin
					req_reg   <= 1'b1;
					write_reg <= 1'b1;
					addr_reg  <= `BLK_PWR_ADDR;
					wdata_reg <= PWR_EN;
				end
				adc_pwr_seq_pkg::ST_SLEEP_WR: begin
					req_reg   <= 1'b1;
					write_reg <= 1'b1;
					addr_reg  <= `SLEEP_CTRL_ADDR;
					wdata_reg <= `SLEEP_SET_VAL;
				end
				adc_pwr_seq_pkg::ST_STAT_RD: begin
					req_reg   <= 1'b1;
					write_reg <= 1'b0;
					addr_reg  <= `DEV_STATUS_ADDR;
					wdata_reg <= 8'h00;
				end
				default: begin
					req_reg <= 1'b0;
				end
			endcase
		end
	end

	// shutdown pin follows the sequencer; low from reset onward
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			pin_reg <= 1'b0;
		end else begin
			pin_reg <= (state_next != adc_pwr_seq_pkg::ST_HWSHDN);
		end
	end

	// ==========================================================
	// serial clocks
	// clocks run from active until the status read confirms sleep or a shutdown
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			clk_run_reg <= 1'b0;
		end else begin
			clk_run_reg <= (state_next == adc_pwr_seq_pkg::ST_ACTIVE) ||
				       (state_next == adc_pwr_seq_pkg::ST_SLEEP_WR) ||
				       (state_next == adc_pwr_seq_pkg::ST_SLEEP_WAIT) ||
				       (state_next == adc_pwr_seq_pkg::ST_STAT_RD);
		end
	end

	// divider: bit clock and a one-bit frame sync at bit zero;
	// stopping mid-frame is accepted since the device is asleep
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			div_reg   <= 16'h0000;
			bit_reg   <= 16'h0000;
			bclk_reg  <= 1'b0;
			frame_sync_reg <= 1'b0;
		end else if (!clk_run_reg) begin
			div_reg   <= 16'h0000;
			bit_reg   <= 16'h0000;
			bclk_reg  <= 1'b0;
			frame_sync_reg <= 1'b0;
		end else if (div_reg == 16'(BCLK_HALF - 1)) begin
			div_reg  <= 16'h0000;
			bclk_reg <= ~bclk_reg;
			if (bclk_reg) begin
				// falling edge: move to the next bit of the frame
				if (bit_reg == 16'(FRAME_BITS - 1)) begin
					bit_reg   <= 16'h0000;
					frame_sync_reg <= 1'b1;
				end else begin
					bit_reg   <= bit_reg + 16'h0001;
					frame_sync_reg <= 1'b0;
				end
			end else if (bit_reg == 16'h0000) begin
				frame_sync_reg <= 1'b1;
			end
		end else begin
			div_reg <= div_reg + 16'h0001;
		end
	end

	// ==========================================================
	// outputs
	assign REG_REQ        = req_reg;
	assign REG_WRITE      = write_reg;
	assign REG_ADDR       = addr_reg;
	assign REG_WDATA      = wdata_reg;
	assign SHUTDOWN_N_PIN = pin_reg;
	assign BIT_CLK        = bclk_reg;
	assign FRAME_SYNC     = frame_sync_reg;
	assign SLEEP_DONE     = sleep_done_reg;
	assign RECORDING      = clk_run_reg;
	assign STATE_CODE     = state_reg;

endmodule

// *** adc_pwr_seq_defines.svh ***
// constants for the adc power-mode sequencer host controller
`ifndef ADC_PWR_SEQ_DEFINES_SVH
`define ADC_PWR_SEQ_DEFINES_SVH

// ==========================================================
// reference clock and wait times
`define REF_CLK_KHZ        20000
`define INIT_WAIT_US       1000
`define WAKE_WAIT_US       1000
`define SLEEP_WAIT_US      6000
`define INIT_WAIT_CYC      ((`INIT_WAIT_US * `REF_CLK_KHZ + 999) / 1000)
`define WAKE_WAIT_CYC      ((`WAKE_WAIT_US * `REF_CLK_KHZ + 999) / 1000)
`define SLEEP_WAIT_CYC     ((`SLEEP_WAIT_US * `REF_CLK_KHZ + 999) / 1000)

// ==========================================================
// device register offsets (page 0)
`define SLEEP_CTRL_ADDR    8'h02
`define IN_CH_EN_ADDR      8'h73
`define OUT_SLOT_EN_ADDR   8'h74
`define BLK_PWR_ADDR       8'h75
`define DEV_STATUS_ADDR    8'h77
`define SLEEP_DONE_BIT     7

// ==========================================================
// sleep control write values
`define SLEEP_CLEAR_VAL    8'h81
`define SLEEP_SET_VAL      8'h80

// ==========================================================
// serial clock generation
`define BCLK_HALF_DEF      4
`define FRAME_BITS_DEF     64

`endif

// *** adc_pwr_seq_pkg.sv ***
// types for the adc power-mode sequencer host controller
package adc_pwr_seq_pkg;

	// ==========================================================
	// sequencer states
	typedef enum logic [3:0] {
		ST_HWSHDN     = 4'b0000,
		ST_INIT_WAIT  = 4'b0001,
		ST_SLEEP      = 4'b0010,
		ST_WAKE_WR    = 4'b0011,
		ST_WAKE_WAIT  = 4'b0100,
		ST_CFG_CH     = 4'b0101,
		ST_CFG_SLOT   = 4'b0110,
		ST_CFG_PWR    = 4'b0111,
		ST_ACTIVE     = 4'b1000,
		ST_SLEEP_WR   = 4'b1001,
		ST_SLEEP_WAIT = 4'b1010,
		ST_STAT_RD    = 4'b1011
	} seq_state_t;

endpackage

// *** adc_pwr_seq_props.sv ***
// port checker for the power-mode sequencer
`timescale 1ns/100ps
`include "adc_pwr_seq_defines.svh"
module adc_pwr_seq_props #(
	parameter int INIT_CYC  = `INIT_WAIT_CYC,
	parameter int WAKE_CYC  = `WAKE_WAIT_CYC,
	parameter int SLEEP_CYC = `SLEEP_WAIT_CYC
) (
	input wire logic       REF_CLK,
	input wire logic       RSTN,
	input wire logic       CMD_SHUTDOWN,
	input wire logic       REG_REQ,
	input wire logic       REG_WRITE,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic       REG_ACK,
	input wire logic [7:0] REG_RDATA,
	input wire logic       SHUTDOWN_N_PIN,
	input wire logic       RECORDING
);
	// wide enough for the full-length sleep wait at the real clock
	logic [31:0] up_reg;
	logic [31:0] idle_reg;
	logic [7:0]  last_reg;
	logic        set_reg;
	logic        clr_reg;
	wire         fin  = REG_REQ && REG_ACK;
	wire         sc   = REG_WRITE && REG_ADDR == `SLEEP_CTRL_ADDR;
	wire         done = REG_ACK && !REG_WRITE && REG_RDATA[`SLEEP_DONE_BIT];
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);
	// ==========================================
	// cycles since the pin went high
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			up_reg <= 32'h0000_0000;
		end else begin
			up_reg <= SHUTDOWN_N_PIN ? up_reg + 32'h0000_0001 :
				  32'h0000_0000;
		end
	end
	// last finished access, so each wait is timed from its own write
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			idle_reg <= 32'h0000_0000;
			last_reg <= 8'h00;
			set_reg  <= 1'b0;
			clr_reg  <= 1'b0;
		end else if (fin) begin
			idle_reg <= 32'h0000_0000;
			last_reg <= REG_ADDR;
			set_reg  <= sc && REG_WDATA == `SLEEP_SET_VAL;
			clr_reg  <= sc && REG_WDATA == `SLEEP_CLEAR_VAL;
		end else begin
			idle_reg <= idle_reg + 32'h0000_0001;
		end
	end
	// ==========================================
	// properties
	property p_shdn;
		CMD_SHUTDOWN ##1 CMD_SHUTDOWN |-> !SHUTDOWN_N_PIN && !REG_REQ;
	endproperty
	a_shdn: assert property (p_shdn) else $error("pin up");
	property p_nogo;
		REG_REQ |-> SHUTDOWN_N_PIN;
	endproperty
	a_nogo: assert property (p_nogo) else $error("access in shdn");
	property p_init;
		REG_REQ |-> up_reg >= INIT_CYC;
	endproperty
	a_init: assert property (p_init) else $error("init early");
	property p_wake;
		($rose(REG_REQ) || $rose(RECORDING)) && clr_reg |-> idle_reg >= WAKE_CYC;
	endproperty
	a_wake: assert property (p_wake) else $error("wake early");
	property p_sleep;
		$rose(REG_REQ) && set_reg |-> idle_reg >= SLEEP_CYC;
	endproperty
	a_sleep: assert property (p_sleep) else $error("read early");
	property p_stop;
		$fell(RECORDING) && SHUTDOWN_N_PIN && !$past(CMD_SHUTDOWN) |-> $past(done);
	endproperty
	a_stop: assert property (p_stop) else $error("clk stop early");
	property p_order;
		REG_REQ && REG_ADDR == `OUT_SLOT_EN_ADDR |-> last_reg == `IN_CH_EN_ADDR;
	endproperty
	a_order: assert property (p_order) else $error("slot order");
	property p_hold;
		REG_REQ && !REG_ACK && !CMD_SHUTDOWN
			|=> REG_REQ && $stable(REG_ADDR) && $stable(REG_WDATA);
	endproperty
	a_hold: assert property (p_hold) else $error("req moved");
endmodule
bind adc_power_mode_sequencer adc_pwr_seq_props #(
	.INIT_CYC(INIT_CYC), .WAKE_CYC(WAKE_CYC), .SLEEP_CYC(SLEEP_CYC)
) u_props (
	.REF_CLK(REF_CLK), .RSTN(RSTN), .CMD_SHUTDOWN(CMD_SHUTDOWN),
	.REG_REQ(REG_REQ), .REG_WRITE(REG_WRITE), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_ACK(REG_ACK), .REG_RDATA(REG_RDATA),
	.SHUTDOWN_N_PIN(SHUTDOWN_N_PIN), .RECORDING(RECORDING)
);

// *** adc_dev_model.sv ***
// behavioural device model on the register port
`timescale 1ns/100ps
`include "adc_pwr_seq_defines.svh"
module adc_dev_model (
	input  wire logic       clk,
	input  wire logic       pin_n,
	input  wire logic       slow,
	input  wire logic       req,
	input  wire logic       wr,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	output logic            ack,
	output logic      [7:0] rdata
);
	logic [7:0] regs [0:255];
	logic [2:0] lat_reg;
	logic [1:0] pend_reg;
	logic       asleep_reg;
	// pin low is hardware shutdown; rdata churns when not answering
	always_ff @(posedge clk or negedge pin_n) begin
		if (!pin_n) begin
			ack        <= 1'b0;
			lat_reg    <= 3'h0;
			pend_reg   <= 2'h0;
			asleep_reg <= 1'b1;
			rdata      <= 8'hA5;
		end else if (req && !ack && lat_reg < {slow, 2'h0}) begin
			lat_reg <= lat_reg + 3'h1;
			rdata   <= ~rdata;
		end else if (req && !ack) begin
			ack     <= 1'b1;
			lat_reg <= 3'h0;
			rdata   <= addr == `DEV_STATUS_ADDR ?
				{asleep_reg && pend_reg == 2'h0, 7'h00} : regs[addr];
			if (wr) begin
				regs[addr] <= wdata;
			end
			if (wr && addr == `SLEEP_CTRL_ADDR) begin
				asleep_reg <= !wdata[0];
				pend_reg   <= wdata[0] ? 2'h0 : 2'h2;
			end else if (addr == `DEV_STATUS_ADDR && pend_reg != 2'h0) begin
				// ramp-down outlasts the first status reads
				pend_reg <= pend_reg - 2'h1;
			end
		end else begin
			ack   <= 1'b0;
			rdata <= ~rdata;
		end
	end
endmodule

// *** test_adc_power_mode_sequencer.sv ***
// self-checking bench for the power-mode sequencer
`timescale 1ns/100ps
module test_adc_power_mode_sequencer;
	localparam int FB = 8;
	localparam int BH = 2;
	logic        REF_CLK = 1'b0;
	logic        RSTN = 1'b0;
	logic        SUPPLY_OK = 1'b0;
	logic        CMD_WAKE = 1'b0;
	logic        CMD_SLEEP = 1'b0;
	logic        CMD_SHUTDOWN = 1'b0;
	logic        slow = 1'b0;
	logic [7:0]  CH_EN = 8'hF0;
	logic [7:0]  SLOT_EN = 8'h3C;
	logic [7:0]  PWR_EN = 8'hE0;
	logic        REG_REQ, REG_WRITE, REG_ACK, SHUTDOWN_N_PIN, BIT_CLK;
	logic        FRAME_SYNC, SLEEP_DONE, RECORDING;
	logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA;
	logic [3:0]  STATE_CODE;
	logic [15:0] log_q [$];
	int          n_fail = 0;
	int          check_count = 0;
	// ==========================================
	// design, device model, clock and access log
	adc_power_mode_sequencer #(.INIT_CYC(20), .WAKE_CYC(20), .SLEEP_CYC(50),
		.BCLK_HALF(BH), .FRAME_BITS(FB)) u_dut (
		.REF_CLK(REF_CLK), .RSTN(RSTN), .SUPPLY_OK(SUPPLY_OK),
		.CMD_WAKE(CMD_WAKE), .CMD_SLEEP(CMD_SLEEP),
		.CMD_SHUTDOWN(CMD_SHUTDOWN), .CH_EN(CH_EN), .SLOT_EN(SLOT_EN),
		.PWR_EN(PWR_EN), .REG_REQ(REG_REQ), .REG_WRITE(REG_WRITE),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_ACK(REG_ACK),
		.REG_RDATA(REG_RDATA), .SHUTDOWN_N_PIN(SHUTDOWN_N_PIN),
		.BIT_CLK(BIT_CLK), .FRAME_SYNC(FRAME_SYNC), .SLEEP_DONE(SLEEP_DONE),
		.RECORDING(RECORDING), .STATE_CODE(STATE_CODE));
	adc_dev_model u_dev (.clk(REF_CLK), .pin_n(SHUTDOWN_N_PIN), .slow(slow),
		.req(REG_REQ), .wr(REG_WRITE), .addr(REG_ADDR), .wdata(REG_WDATA),
		.ack(REG_ACK), .rdata(REG_RDATA));
	initial forever #25 REF_CLK = ~REF_CLK;
	// reads are logged with EE so they never match a write
	always @(posedge REF_CLK) if (REG_REQ && REG_ACK)
		log_q.push_back({REG_ADDR, REG_WRITE ? REG_WDATA : 8'hEE});
	// ==========================================
	// tasks
	task automatic check(input string nm, input logic [15:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge REF_CLK);
		#1;
	endtask
	task automatic cmd(input logic [2:0] c, input int n);
		{CMD_WAKE, CMD_SLEEP, CMD_SHUTDOWN} = c;
		cyc(n);
		{CMD_WAKE, CMD_SLEEP, CMD_SHUTDOWN} = 3'b000;
	endtask
	task automatic wait_st(input logic [3:0] s);
		int i;
		for (i = 0; i < 500 && STATE_CODE !== s; i++) cyc(1);
		check("state", STATE_CODE, s);
	endtask
	task automatic check_log(input logic [15:0] exp [$]);
		check("log size", 16'(log_q.size()), 16'(exp.size()));
		foreach (exp[k]) check("access", log_q[k], exp[k]);
		log_q.delete();
	endtask
	// frame sync low span: all bits of the frame but the first
	task automatic frame_low();
		int n;
		for (n = 0; n < 99 && FRAME_SYNC !== 1'b1; n++) cyc(1);
		for (n = 0; n < 99 && FRAME_SYNC !== 1'b0; n++) cyc(1);
		for (n = 0; n < 99 && FRAME_SYNC !== 1'b1; n++) cyc(1);
		check("fs low", 16'(n), 16'((FB - 1) * 2 * BH));
		// frame sync rises with the falling bit clock edge
		check("bclk lo", BIT_CLK, 1'b0);
		cyc(BH);
		check("bclk hi", BIT_CLK, 1'b1);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ==========================================
	// main sequence
	initial begin
		cyc(3);
		RSTN = 1'b1;
		cyc(30);
		check("pin no supply", SHUTDOWN_N_PIN, 1'b0);
		SUPPLY_OK = 1'b1;
		wait_st(4'h2);
		cmd(3'b010, 1);
		cyc(4);
		check("refused", STATE_CODE, 4'h2);
		cmd(3'b100, 1);
		wait_st(4'h8);
		check_log('{16'h0281, 16'h73F0, 16'h743C, 16'h75E0});
		frame_low();
		slow = 1'b1;
		cmd(3'b010, 1);
		wait_st(4'h2);
		cyc(1);
		check_log('{16'h0280, 16'h77EE, 16'h77EE, 16'h77EE});
		check("done", SLEEP_DONE, 1'b1);
		check("stop", {RECORDING, BIT_CLK, FRAME_SYNC}, 3'b000);
		check("kept", u_dev.regs[8'h73], 8'hF0);
		cmd(3'b100, 1);
		wait_st(4'h8);
		cyc(2);
		check("rec", RECORDING, 1'b1);
		check("done clr", SLEEP_DONE, 1'b0);
		check_log('{16'h0281});
		cmd(3'b001, 3);
		check("hw shdn", {SHUTDOWN_N_PIN, STATE_CODE}, 5'h00);
		wait_st(4'h2);
		cmd(3'b100, 1);
		wait_st(4'h8);
		check_log('{16'h0281, 16'h73F0, 16'h743C, 16'h75E0});
		// losing the supplies must act like the shutdown command
		SUPPLY_OK = 1'b0;
		cyc(6);
		check("supply lost", {SHUTDOWN_N_PIN, STATE_CODE}, 5'h00);
		check("rec off", RECORDING, 1'b0);
		give_verdict();
	end
	// watchdog at 20000 cycles, far beyond the few hundred cycles the run needs
	initial begin
		#(20000 * 50);
		n_fail++;
		give_verdict();
	end
endmodule
